// ### design/lsw_pkg.sv
// Shared constants and types for the LED switch command unit and its bus master
package lsw_pkg;
   // Channel count and command address prefixes
   localparam int          CH_N       = 8;
   localparam logic [2:0]  AC_PFX     = 3'h2;
   localparam logic [2:0]  SC_PFX     = 3'h5;
   // Reset values, plus the overheat fault value and the zero dimming value
   localparam logic [7:0]  SW_RST     = 8'hFF;
   localparam logic [7:0]  FAULT_RST  = 8'h00;
   localparam logic [7:0]  FAULT_ALL  = 8'hFF;
   localparam logic [13:0] CFG_RST    = 14'h3101;
   localparam logic [7:0]  DV_MIN     = 8'h01;
   localparam logic [7:0]  DV_ZERO    = 8'h00;
   localparam logic [6:0]  SYNC_RST   = 7'h03;
   // Switch mode encodings
   localparam logic [1:0]  MC_OFF     = 2'h0;
   localparam logic [1:0]  MC_ON      = 2'h1;
   localparam logic [1:0]  MC_PWM     = 2'h2;
   localparam logic [1:0]  MC_FADE    = 2'h3;
   // Bit slot numbers within a nine-bit frame
   localparam logic [3:0]  BIT_LAST   = 4'h7;
   localparam logic [3:0]  BIT_ACK    = 4'h8;
   // Host register offsets and fields
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] TX_OFS     = 12'h004;
   localparam logic [11:0] RX_OFS     = 12'h008;
   localparam logic [11:0] STAT_OFS   = 12'h00C;
   localparam int          CTRL_GO    = 31;
   localparam int          CTRL_CNT   = 8;
   // Timing of the serial clock made by the host
   localparam int          CLK_HZ     = 40000000;
   localparam int          SCL_HZ     = 400000;
   localparam int          QTR_CYC    = CLK_HZ / (4 * SCL_HZ);
   // Device receiver states, Gray along idle-address-write/read
   typedef enum logic [1:0] {
      D_IDLE = 2'h0,
      D_ADDR = 2'h1,
      D_WR   = 2'h3,
      D_RD   = 2'h2
   } lsw_dst_t;
   // Host sequencer states
   typedef enum logic [1:0] {
      H_IDLE  = 2'h0,
      H_START = 2'h1,
      H_BIT   = 2'h3,
      H_STOP  = 2'h2
   } lsw_hst_t;
endpackage

// ### design/lsw_if.sv
// Two-wire serial bus between the host controller and the LED switch device
`timescale 1ns/100ps
interface lsw_if;
   // Host drives the clock, both ends pull the data line low
   logic scl_o;
   logic scl_oe;
   logic h_sda_o;
   logic h_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;
   // Open-drain resolution with pull-ups
   assign scl = !(scl_oe && !scl_o);
   assign sda = !(h_sda_oe && !h_sda_o) && !(d_sda_oe && !d_sda_o);
   modport dev (
      input  scl,
      input  sda,
      output d_sda_o,
      output d_sda_oe
   );
   modport host (
      input  scl,
      input  sda,
      output scl_o,
      output scl_oe,
      output h_sda_o,
      output h_sda_oe
   );
endinterface

// ### design/lsw_device.sv
// Command decoder and register file of the eight-channel LED bypass switch
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
// Operation
// - Zero dimming value is stored as one
// - Open and short fault status, reset zero
// - Overheat sets all fault status bits
// - Ack address and data, latch at ack
// - Staged data survives repeated start
// - Staged data commits only at stop
// - Thresholds update immediately at ack
// - Read: master acks all but last byte
// - Reads before stop return staged data
// - Master sends address; direction picks sender
// - All-channel write is exactly two bytes
// - All-channel read returns switch, open, short
// - All-channel address is 010 plus id pins
// - Switch changes follow stop within microsecond
// - Slow driver: change one channel per write
// - Short write sets open threshold, mode
// - Long write sets short threshold, mode, dimming
// - Short second byte: 0, channel, threshold, mode
// - Long second byte: 1, channel, threshold, mode
// - Mode decode off, on, PWM, PWM fade
// - All-channel switch register resets all ones
// - Remember last written channel, default 000
module lsw_device (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Serial bus
   lsw_if.dev                bus,
   // Board pins and fault sense
   input  wire logic [3:0]   bus_id_sel,
   input  wire logic         overheat_in,
   input  wire logic [7:0]   open_fault_in,
   input  wire logic [7:0]   short_fault_in,
   // Register contents and channel controls
   output logic [7:0]        all_channel_switch_register,
   output logic [7:0][13:0]  per_channel_config_register,
   output logic [7:0]        open_fault_status,
   output logic [7:0]        short_fault_status,
   output logic [7:0]        led_on,
   output logic [7:0]        pwm_en,
   output logic [7:0]        fade_en
);
   logic [6:0]        raw;
   logic [6:0]        s1_q;
   logic [6:0]        s2_q;
   logic [6:0]        s3_q;
   logic [6:0]        lv_q;
   logic [6:0]        lv_d;
   logic              scl_p_q;
   logic              sda_p_q;
   lsw_pkg::lsw_dst_t st_q;
   logic [3:0]        bit_q;
   logic [1:0]        byte_q;
   logic [1:0]        byte_inc;
   logic              sc_q;
   logic              long_q;
   logic [2:0]        ch_q;
   logic [7:0]        sh_q;
   logic [7:0]        tx_q;
   logic              oe_q;
   logic [7:0]        sw_q;
   logic [7:0]        ssw_q;
   logic              swp_q;
   logic [7:0]        olf_q;
   logic [7:0]        slf_q;
   logic [7:0][13:0]  view;
   logic [7:0]        rd_byte;
   logic [7:0]        ac_rd;
   logic [7:0]        sc_rd;
   logic [13:0]       cur;
   logic              scl_lv;
   logic              sda_lv;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_ev;
   logic              stop_ev;
   logic              ac_hit;
   logic              sc_hit;
   logic              byte_end;
   logic              wr_ok;
   logic              wr_acc;
   logic              ac_acc;
   logic              cmd_acc;
   logic              dv_acc;

   // Pins pass three flops; a level counts once the last two agree
   assign raw = {overheat_in, bus_id_sel, bus.sda, bus.scl};
   for (genvar i = 0; i < 7; i++) begin : g_sync
      assign lv_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lv_q[i];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q    <= lsw_pkg::SYNC_RST;
         s2_q    <= lsw_pkg::SYNC_RST;
         s3_q    <= lsw_pkg::SYNC_RST;
         lv_q    <= lsw_pkg::SYNC_RST;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         s1_q    <= raw;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         lv_q    <= lv_d;
         scl_p_q <= lv_q[0];
         sda_p_q <= lv_q[1];
      end
   end

   // Bus events and address match
   assign scl_lv   = lv_q[0];
   assign sda_lv   = lv_q[1];
   assign scl_rise = scl_lv && !scl_p_q;
   assign scl_fall = !scl_lv && scl_p_q;
   assign start_ev = scl_lv && scl_p_q && sda_p_q && !sda_lv;
   assign stop_ev  = scl_lv && scl_p_q && !sda_p_q && sda_lv;
   assign ac_hit   = (sh_q[7:1] == {lsw_pkg::AC_PFX, lv_q[5:2]});
   assign sc_hit   = (sh_q[7:1] == {lsw_pkg::SC_PFX, lv_q[5:2]});
   assign byte_end = scl_fall && (bit_q == lsw_pkg::BIT_LAST);
   assign byte_inc = (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;

   // Write bytes accepted: one for all-channel, two only after a long header
   assign wr_ok   = (byte_q == 2'h0) || (sc_q && long_q && byte_q == 2'h1);
   assign wr_acc  = byte_end && (st_q == lsw_pkg::D_WR) && wr_ok;
   assign ac_acc  = wr_acc && !sc_q;
   assign cmd_acc = wr_acc && sc_q && (byte_q == 2'h0);
   assign dv_acc  = wr_acc && sc_q && (byte_q == 2'h1);

   // Read data: staged view where pending, otherwise committed
   assign cur   = view[ch_q];
   assign ac_rd = (byte_q == 2'h0) ? (swp_q ? ssw_q : sw_q) :
                  (byte_q == 2'h1) ? olf_q :
                  (byte_q == 2'h2) ? slf_q : 8'h00;
   assign sc_rd = (byte_q == 2'h0) ? {olf_q[ch_q], slf_q[ch_q], cur[13:8]} :
                  (byte_q == 2'h1) ? cur[7:0] : 8'h00;
   assign rd_byte = sc_q ? sc_rd : ac_rd;

   // Frame engine: sample on rising clock, drive on falling clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q   <= lsw_pkg::D_IDLE;
         bit_q  <= 4'h0;
         byte_q <= 2'h0;
         sc_q   <= 1'b0;
         sh_q   <= 8'h00;
         tx_q   <= 8'h00;
         oe_q   <= 1'b0;
      end else if (start_ev) begin
         st_q  <= lsw_pkg::D_ADDR;
         // Park in the ack slot so the clock fall that ends the start is not counted as a bit
         bit_q <= lsw_pkg::BIT_ACK;
         oe_q  <= 1'b0;
      end else if (stop_ev) begin
         st_q <= lsw_pkg::D_IDLE;
         oe_q <= 1'b0;
      end else if (scl_rise && st_q != lsw_pkg::D_IDLE) begin
         if (bit_q != lsw_pkg::BIT_ACK) begin
            sh_q <= {sh_q[6:0], sda_lv};
         end else if (st_q == lsw_pkg::D_RD && sda_lv) begin
            st_q <= lsw_pkg::D_IDLE;
         end
      end else if (scl_fall && st_q != lsw_pkg::D_IDLE) begin
         if (bit_q == lsw_pkg::BIT_LAST) begin
            bit_q <= lsw_pkg::BIT_ACK;
            if (st_q == lsw_pkg::D_ADDR) begin
               oe_q   <= ac_hit || sc_hit;
               sc_q   <= sc_hit;
               byte_q <= 2'h0;
               if (!(ac_hit || sc_hit)) begin
                  st_q <= lsw_pkg::D_IDLE;
               end else if (sh_q[0]) begin
                  st_q <= lsw_pkg::D_RD;
               end else begin
                  st_q <= lsw_pkg::D_WR;
               end
            end else if (st_q == lsw_pkg::D_WR) begin
               oe_q   <= wr_ok;
               byte_q <= byte_inc;
               if (!wr_ok) begin
                  st_q <= lsw_pkg::D_IDLE;
               end
            end else begin
               oe_q   <= 1'b0;
               byte_q <= byte_inc;
            end
         end else if (bit_q == lsw_pkg::BIT_ACK) begin
            bit_q <= 4'h0;
            oe_q  <= (st_q == lsw_pkg::D_RD) && !rd_byte[7];
            tx_q  <= {rd_byte[6:0], 1'b0};
         end else begin
            bit_q <= bit_q + 4'h1;
            oe_q  <= (st_q == lsw_pkg::D_RD) && !tx_q[7];
            tx_q  <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // Header byte staging and last channel memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_q   <= 3'h0;
         long_q <= 1'b0;
      end else if (cmd_acc) begin
         ch_q   <= sh_q[6:4];
         long_q <= sh_q[7];
      end
   end

   // All-channel switch register, staged then committed at stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_q  <= lsw_pkg::SW_RST;
         ssw_q <= lsw_pkg::SW_RST;
         swp_q <= 1'b0;
      end else if (stop_ev) begin
         if (swp_q) begin
            sw_q <= ssw_q;
         end
         swp_q <= 1'b0;
      end else if (ac_acc) begin
         ssw_q <= sh_q;
         swp_q <= 1'b1;
      end
   end

   // Fault status mirrors the sense inputs, forced high on overheat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         olf_q <= lsw_pkg::FAULT_RST;
         slf_q <= lsw_pkg::FAULT_RST;
      end else if (lv_q[6]) begin
         olf_q <= lsw_pkg::FAULT_ALL;
         slf_q <= lsw_pkg::FAULT_ALL;
      end else begin
         olf_q <= open_fault_in;
         slf_q <= short_fault_in;
      end
   end

   // Per-channel configuration, holding latches and mode decode
   for (genvar c = 0; c < lsw_pkg::CH_N; c++) begin : g_ch
      logic [13:0] cfg_q;
      logic [1:0]  smc_q;
      logic [7:0]  sdv_q;
      logic        mp_q;
      logic        dp_q;
      logic        hit;
      logic        dhit;
      assign hit  = cmd_acc && (sh_q[6:4] == 3'(c));
      assign dhit = dv_acc && (ch_q == 3'(c));
      assign view[c] = {cfg_q[13:10], mp_q ? smc_q : cfg_q[9:8], dp_q ? sdv_q : cfg_q[7:0]};
      assign per_channel_config_register[c] = cfg_q;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cfg_q <= lsw_pkg::CFG_RST;
            smc_q <= lsw_pkg::MC_OFF;
            sdv_q <= lsw_pkg::DV_MIN;
            mp_q  <= 1'b0;
            dp_q  <= 1'b0;
         end else if (stop_ev) begin
            if (mp_q) begin
               cfg_q[9:8] <= smc_q;
            end
            if (dp_q) begin
               cfg_q[7:0] <= sdv_q;
            end
            mp_q <= 1'b0;
            dp_q <= 1'b0;
         end else if (hit) begin
            if (sh_q[7]) begin
               cfg_q[11:10] <= sh_q[3:2];
            end else begin
               cfg_q[13:12] <= sh_q[3:2];
            end
            smc_q <= sh_q[1:0];
            mp_q  <= 1'b1;
         end else if (dhit) begin
            sdv_q <= (sh_q == lsw_pkg::DV_ZERO) ? lsw_pkg::DV_MIN : sh_q;
            dp_q  <= 1'b1;
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            led_on[c]  <= 1'b0;
            pwm_en[c]  <= 1'b0;
            fade_en[c] <= 1'b0;
         end else begin
            led_on[c]  <= (cfg_q[9:8] == lsw_pkg::MC_ON);
            pwm_en[c]  <= (cfg_q[9:8] == lsw_pkg::MC_PWM) || (cfg_q[9:8] == lsw_pkg::MC_FADE);
            fade_en[c] <= (cfg_q[9:8] == lsw_pkg::MC_FADE);
         end
      end
   end

   // Outputs
   assign all_channel_switch_register = sw_q;
   assign open_fault_status           = olf_q;
   assign short_fault_status          = slf_q;
   assign bus.d_sda_o                 = 1'b0;
   assign bus.d_sda_oe                = oe_q;
endmodule

// ### design/lsw_host.sv
// APB-controlled two-wire bus master that issues commands to the LED switch
`timescale 1ns/100ps
module lsw_host #(
   parameter int QTR = lsw_pkg::QTR_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Serial bus
   lsw_if.host              bus
);
   logic              pready_q;
   logic [31:0]       prdata_q;
   logic              pslverr_q;
   logic [7:0]        addr_q;
   logic [1:0]        cnt_q;
   logic [23:0]       tx_q;
   logic [23:0]       rx_q;
   logic              nack_q;
   lsw_pkg::lsw_hst_t st_q;
   logic [15:0]       qc_q;
   logic [1:0]        ph_q;
   logic [3:0]        bit_q;
   logic [1:0]        byte_q;
   logic [7:0]        sh_q;
   logic              scl_oe_q;
   logic              sda_oe_q;
   logic              s1_q;
   logic              s2_q;
   logic              s3_q;
   logic              sda_lv_q;
   logic              acc;
   logic              wr_fire;
   logic              hit_ctrl;
   logic              hit_tx;
   logic              hit_rx;
   logic              hit_st;
   logic [31:0]       rdata;
   logic              go;
   logic              tick;
   logic              mine;
   logic              last;
   logic [7:0]        tx_next;

   // APB decode; answer one cycle into the access phase
   assign acc      = psel && penable && !pready_q;
   assign wr_fire  = psel && penable && pready_q && pwrite;
   assign hit_ctrl = (paddr == lsw_pkg::CTRL_OFS);
   assign hit_tx   = (paddr == lsw_pkg::TX_OFS);
   assign hit_rx   = (paddr == lsw_pkg::RX_OFS);
   assign hit_st   = (paddr == lsw_pkg::STAT_OFS);
   assign rdata    = hit_ctrl ? {22'h0, cnt_q, addr_q} :
                     hit_tx   ? {8'h00, tx_q} :
                     hit_rx   ? {8'h00, rx_q} :
                     hit_st   ? {30'h0, nack_q, st_q != lsw_pkg::H_IDLE} : 32'h0;
   assign go       = wr_fire && hit_ctrl && pwdata[lsw_pkg::CTRL_GO] && (st_q == lsw_pkg::H_IDLE);

   // APB answer flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= acc;
         prdata_q  <= acc ? rdata : 32'h0;
         pslverr_q <= acc && !(hit_ctrl || hit_tx || hit_rx || hit_st);
      end
   end

   // Command registers; writes to CTRL ignored while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= 8'h00;
         cnt_q  <= 2'h0;
         tx_q   <= 24'h0;
      end else if (wr_fire && hit_ctrl && st_q == lsw_pkg::H_IDLE) begin
         addr_q <= pwdata[7:0];
         cnt_q  <= pwdata[lsw_pkg::CTRL_CNT +: 2];
      end else if (wr_fire && hit_tx) begin
         tx_q <= pwdata[23:0];
      end
   end

   // Data line synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q     <= 1'b1;
         s2_q     <= 1'b1;
         s3_q     <= 1'b1;
         sda_lv_q <= 1'b1;
      end else begin
         s1_q     <= bus.sda;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         sda_lv_q <= (s2_q == s3_q) ? s3_q : sda_lv_q;
      end
   end

   // Bit timing: four phases per serial clock period
   assign tick    = (qc_q == 16'h0);
   assign mine    = (byte_q == 2'h0) || !addr_q[0];
   assign last    = (byte_q == cnt_q);
   assign tx_next = (byte_q == 2'h0) ? tx_q[7:0] : (byte_q == 2'h1) ? tx_q[15:8] : tx_q[23:16];

   // Sequencer: start, frames of nine bits, stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q     <= lsw_pkg::H_IDLE;
         qc_q     <= 16'h0;
         ph_q     <= 2'h0;
         bit_q    <= 4'h0;
         byte_q   <= 2'h0;
         sh_q     <= 8'h00;
         rx_q     <= 24'h0;
         nack_q   <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (go) begin
         st_q   <= lsw_pkg::H_START;
         qc_q   <= 16'(QTR - 1);
         ph_q   <= 2'h0;
         nack_q <= 1'b0;
      end else if (st_q != lsw_pkg::H_IDLE) begin
         qc_q <= tick ? 16'(QTR - 1) : qc_q - 16'h1;
         if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (st_q)
               lsw_pkg::H_START: begin
                  if (ph_q == 2'h1) sda_oe_q <= 1'b1;
                  if (ph_q == 2'h2) scl_oe_q <= 1'b1;
                  if (ph_q == 2'h3) begin
                     st_q   <= lsw_pkg::H_BIT;
                     sh_q   <= addr_q;
                     bit_q  <= 4'h0;
                     byte_q <= 2'h0;
                  end
               end
               lsw_pkg::H_BIT: begin
                  if (ph_q == 2'h0) begin
                     if (bit_q != lsw_pkg::BIT_ACK) sda_oe_q <= mine && !sh_q[7];
                     else sda_oe_q <= !mine && !last;
                  end
                  if (ph_q == 2'h1) scl_oe_q <= 1'b0;
                  if (ph_q == 2'h2) begin
                     if (bit_q != lsw_pkg::BIT_ACK) sh_q <= {sh_q[6:0], sda_lv_q};
                     else if (mine && sda_lv_q) nack_q <= 1'b1;
                  end
                  if (ph_q == 2'h3) begin
                     scl_oe_q <= 1'b1;
                     if (bit_q != lsw_pkg::BIT_ACK) begin
                        bit_q <= bit_q + 4'h1;
                     end else begin
                        bit_q  <= 4'h0;
                        byte_q <= byte_q + 2'h1;
                        sh_q   <= tx_next;
                        if (!mine) rx_q <= {rx_q[15:0], sh_q};
                        if (last || nack_q) st_q <= lsw_pkg::H_STOP;
                     end
                  end
               end
               lsw_pkg::H_STOP: begin
                  if (ph_q == 2'h0) sda_oe_q <= 1'b1;
                  if (ph_q == 2'h1) scl_oe_q <= 1'b0;
                  if (ph_q == 2'h2) sda_oe_q <= 1'b0;
                  if (ph_q == 2'h3) st_q <= lsw_pkg::H_IDLE;
               end
               default: st_q <= lsw_pkg::H_IDLE;
            endcase
         end
      end
   end

   // Outputs
   assign pready       = pready_q;
   assign prdata       = prdata_q;
   assign pslverr      = pslverr_q;
   assign bus.scl_o    = 1'b0;
   assign bus.scl_oe   = scl_oe_q;
   assign bus.h_sda_o  = 1'b0;
   assign bus.h_sda_oe = sda_oe_q;
endmodule

// ### testbench/lsw_chk.sv
// Assertions on the serial bus joining host and device
`timescale 1ns/100ps
module lsw_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Resolved lines and pull-down enables
   input wire logic scl,
   input wire logic sda,
   input wire logic h_sda_oe,
   input wire logic d_sda_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Stop seen on the wire
   sequence s_stop;
      $rose(sda) && scl && $past(scl);
   endsequence
   // Device changes its data only while the clock is low
   property p_dev_edge; $changed(d_sda_oe) |-> !scl; endproperty
   a_dev_edge: assert property (p_dev_edge) else $error("device data moved with clock high");
   // Only the master ever makes a start
   property p_host_start; $fell(sda) && scl && $past(scl) |-> h_sda_oe; endproperty
   a_host_start: assert property (p_host_start) else $error("start not made by master");
   // Clock phases last at least four cycles
   property p_scl_low; $fell(scl) |=> !scl [*3]; endproperty
   a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
   property p_scl_high; $rose(scl) |=> scl [*3]; endproperty
   a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
   // Device always lets go of the data line in bounded time
   property p_dev_release; $rose(d_sda_oe) |-> ##[1:300] !d_sda_oe; endproperty
   a_dev_release: assert property (p_dev_release) else $error("device holds data line");
   // For eight cycles after a stop the device stays off the line
   property p_stop_idle; s_stop |-> !d_sda_oe [*8]; endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("device drives after stop");
   // Master releases data while the device answers
   property p_host_yield; d_sda_oe && $rose(scl) |-> !h_sda_oe; endproperty
   a_host_yield: assert property (p_host_yield) else $error("master fights device bit");
   // A device bit stands for two cycles after the clock rises
   property p_bit_stands; d_sda_oe && $rose(scl) |=> d_sda_oe [*2]; endproperty
   a_bit_stands: assert property (p_bit_stands) else $error("device bit dropped early");
   // Main scenarios
   c_stop: cover property (s_stop);
   c_dev_drive: cover property ($rose(d_sda_oe));
   c_start: cover property ($fell(sda) && scl);
endmodule

// ### testbench/lsw_bench.sv
// Bench joining host and device, driving APB and checking registers
`timescale 1ns/100ps
module lsw_bench;
   localparam logic [3:0] ID = 4'hA;
   localparam logic [7:0] AW = {lsw_pkg::AC_PFX, ID, 1'b0};
   localparam logic [7:0] SW = {lsw_pkg::SC_PFX, ID, 1'b0};
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, overheat_in, nk;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rx;
   logic [3:0]       bus_id_sel;
   logic [7:0]       open_fault_in, short_fault_in, sw, ofs, sfs, led_on, pwm_en, fade_en;
   logic [7:0][13:0] cfg;
   int               n_errors, tests_run;
   lsw_if lsw_if_i ();
   lsw_device lsw_device_i (.pclk(pclk), .presetn(presetn), .bus(lsw_if_i.dev), .bus_id_sel(bus_id_sel),
      .overheat_in(overheat_in), .open_fault_in(open_fault_in), .short_fault_in(short_fault_in),
      .all_channel_switch_register(sw), .per_channel_config_register(cfg), .open_fault_status(ofs),
      .short_fault_status(sfs), .led_on(led_on), .pwm_en(pwm_en), .fade_en(fade_en));
   lsw_host #(.QTR(4)) lsw_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .bus(lsw_if_i.host));
   lsw_chk lsw_chk_i (.pclk(pclk), .presetn(presetn), .scl(lsw_if_i.scl), .sda(lsw_if_i.sda),
      .h_sda_oe(lsw_if_i.h_sda_oe), .d_sda_oe(lsw_if_i.d_sda_oe));
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rx = prdata;
      nk = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // One serial command; leaves nack in nk and read bytes in rx
   task automatic cmd(input logic [7:0] a, input logic [1:0] n, input logic [15:0] tx);
      logic nack;
      apb(1'b1, lsw_pkg::TX_OFS, {16'h0000, tx});
      apb(1'b1, lsw_pkg::CTRL_OFS, {1'b1, 21'h000000, n, a});
      rx = 32'h00000001;
      while (rx[0] !== 1'b0) apb(1'b0, lsw_pkg::STAT_OFS, 32'h00000000);
      nack = rx[1];
      apb(1'b0, lsw_pkg::RX_OFS, 32'h00000000);
      nk = nack;
      repeat (8) @(posedge pclk);
   endtask
   task automatic t_reset();
      check(sw, lsw_pkg::SW_RST);
      check({ofs, sfs}, 16'h0000);
      for (int c = 0; c < lsw_pkg::CH_N; c++) check(cfg[c], lsw_pkg::CFG_RST);
   endtask
   task automatic t_all();
      cmd(AW, 2'h1, 16'h005A);
      check({nk, sw}, 9'h05A);
      cmd(AW, 2'h1, 16'h005B);
      check({nk, sw}, 9'h05B);
      open_fault_in <= 8'h3C;
      short_fault_in <= 8'h81;
      cmd(AW | 8'h01, 2'h3, 16'h0000);
      check(rx[23:0], 24'h5B3C81);
      overheat_in <= 1'b1;
      cmd(AW | 8'h01, 2'h3, 16'h0000);
      check(rx[23:0], 24'h5BFFFF);
      overheat_in <= 1'b0;
   endtask
   task automatic t_single();
      cmd(SW, 2'h1, 16'h004B);
      check(cfg[4], 14'h2301);
      cmd(SW, 2'h2, 16'h0096);
      check(cfg[1], 14'h3601);
      cmd(SW | 8'h01, 2'h2, 16'h0000);
      check(rx[15:0], 16'h3601);
      for (int m = 0; m < 4; m++) begin
         cmd(SW, 2'h1, {9'h000, 3'h7, 2'h0, m[1:0]});
         check({led_on[7], pwm_en[7], fade_en[7]}, {m == 1, m[1], m == 3});
      end
   endtask
   task automatic t_refuse();
      cmd({lsw_pkg::AC_PFX, ~ID, 1'b0}, 2'h1, 16'h00C3);
      check({nk, sw}, 9'h15B);
      cmd(AW, 2'h2, 16'hC3C3);
      check(nk, 1'b1);
      apb(1'b0, 12'h010, 32'h00000000);
      check(nk, 1'b1);
      check(rx, 32'h00000000);
   endtask
   // Clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, overheat_in} = 5'h00;
      {paddr, pwdata, open_fault_in, short_fault_in} = 60'h0;
      bus_id_sel = ID;
      n_errors = 0;
      tests_run = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      t_reset();
      t_all();
      t_single();
      t_refuse();
      end_of_test();
   end
   // Watchdog against a hung transfer
   initial begin
      #1000000;
      n_errors++;
      end_of_test();
   end
endmodule
